// >>> design/rcf_reset_cause_regs.sv
// Reset-cause flag register bank with APB slave and cause interrupt.
// Assumes cause strobes are one-cycle pulses from the reset logic on clk.
`timescale 1ns/1ps
module rcf_reset_cause_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcf_pkg::ADDR_W-1:0] paddr,
  input wire logic [rcf_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rcf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic powerOnEvt,
  input wire logic brownoutEvt,
  input wire logic resetInstrEvt,
  input wire logic extPinResetEvt,
  input wire logic watchdogTimeoutEvt,
  input wire logic windowViolationEvt,
  input wire logic stackUnderflowEvt,
  input wire logic stackOverflowEvt,
  input wire logic memViolationEvt,
  output logic irq
);
  import rcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CAUSE) || (a == OFS_MEMORY_VIOLATION_FLAG) ||
           (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction

  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic lane0Wr;
  logic lane1Wr;
  logic wrCause;
  logic wrMemv;
  logic wrIrqStatus;
  logic wrIrqMask;

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAccess = accessPhase && pwrite && isMapped(paddr);
  assign lane0Wr = wrAccess && pstrb[0];
  assign lane1Wr = wrAccess && pstrb[1];
  assign wrCause = lane0Wr && (paddr == OFS_CAUSE);
  assign wrMemv = lane0Wr && (paddr == OFS_MEMORY_VIOLATION_FLAG);
  assign wrIrqStatus = (paddr == OFS_IRQ_STATUS) && wrAccess;
  assign wrIrqMask = (paddr == OFS_IRQ_MASK) && wrAccess;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = accessPhase;
  assign pslverr = accessPhase && !isMapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // Register selects

  // One select per register, used only by the read path; the write strobes compare paddr on their own
  function automatic logic isReg(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  logic selCause;
  logic selMemv;
  logic selStatus;
  logic selMask;

  assign selCause = isReg(paddr, OFS_CAUSE);
  assign selMemv = isReg(paddr, OFS_MEMORY_VIOLATION_FLAG);
  assign selStatus = isReg(paddr, OFS_IRQ_STATUS);
  assign selMask = isReg(paddr, OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Cause vector

  logic [CAUSE_N-1:0] causeVec;
  logic [7:0] causeFlags;
  logic memvFlag;

  always_comb begin
    causeVec = '0;
    // Power-on also lands in the brown-out position
    causeVec[BIT_BROWNOUT] = brownoutEvt || powerOnEvt;
    causeVec[BIT_POWER_ON] = powerOnEvt;
    causeVec[BIT_RESET_INSTR] = resetInstrEvt;
    causeVec[BIT_EXT_PIN] = extPinResetEvt;
    causeVec[BIT_WDT_TIMEOUT] = watchdogTimeoutEvt;
    causeVec[BIT_WDT_WINDOW] = windowViolationEvt;
    causeVec[BIT_STK_UNDERFLOW] = stackUnderflowEvt;
    causeVec[BIT_STK_OVERFLOW] = stackOverflowEvt;
    causeVec[EVT_MEM_VIOLATION] = memViolationEvt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag storage, one cell per implemented bit

  // Each cell sees only its own cause (brown-out also sees power-on), so other flags hold, except that power-on loads every cell with its POR value
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gCause
      rcf_flag_bit #(
        .POR_VAL(CAUSE_POR_VAL[gi]),
        .ACTIVE_VAL(CAUSE_ACTIVE_VAL[gi])
      ) uFlag (
        .clk(clk),
        .powerOnLoad(powerOnEvt),
        .causeEvt(causeVec[gi]),
        .swWrite(wrCause),
        .swData(pwdata[gi]),
        .flagQ(causeFlags[gi])
      );
    end
  endgenerate

  rcf_flag_bit #(
    .POR_VAL(MEMORY_VIOLATION_FLAG_POR_VAL),
    .ACTIVE_VAL(MEMORY_VIOLATION_FLAG_ACTIVE_VAL)
  ) uMemvFlag (
    .clk(clk),
    .powerOnLoad(powerOnEvt),
    .causeEvt(causeVec[EVT_MEM_VIOLATION]),
    .swWrite(wrMemv),
    .swData(pwdata[BIT_MEM_VIOLATION]),
    .flagQ(memvFlag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cause interrupt

  logic [CAUSE_N-1:0] irqStatus;
  logic [CAUSE_N-1:0] irqMask;
  logic [CAUSE_N-1:0] irqClearBits;
  logic irqMaskWr;

  // The mask spans two byte lanes; a partial write would leave it half
  // updated, so both lanes must be strobed together
  assign irqMaskWr = wrIrqMask && lane0Wr && lane1Wr;

  // Status clear follows the byte lanes bit for bit
  assign irqClearBits = {pwdata[8] & lane1Wr, pwdata[7:0] & {8{lane0Wr}}};

  rcf_irq_status #(
    .WIDTH(CAUSE_N)
  ) uIrq (
    .clk(clk),
    .reset(reset),
    .eventIn(causeVec),
    .clearWrite(wrIrqStatus),
    .clearBits(irqClearBits),
    .maskWrite(irqMaskWr),
    .maskData(pwdata[CAUSE_N-1:0]),
    .statusQ(irqStatus),
    .maskQ(irqMask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle

  logic [DATA_W-1:0] rdMux;

  // Register views, zero-extended to the bus width.
  // Upper bits are tied low here so reads never depend on lane strobes.
  logic [DATA_W-1:0] causeView;
  logic [DATA_W-1:0] memvView;
  logic [DATA_W-1:0] statusView;
  logic [DATA_W-1:0] maskView;
  logic [7:0] memvByte;

  assign memvByte = {6'h00, memvFlag, 1'b0} & MEMORY_VIOLATION_FLAG_IMPL_MASK;

  assign causeView = {{(DATA_W-8){1'b0}}, causeFlags};

  assign memvView = {{(DATA_W-8){1'b0}}, memvByte};

  assign statusView = {{(DATA_W-CAUSE_N){1'b0}}, irqStatus};

  assign maskView = {{(DATA_W-CAUSE_N){1'b0}}, irqMask};

  // Selects are one-hot, so an AND-OR mux is enough; an unmapped
  // address selects nothing and reads zero
  always_comb begin
    rdMux = '0;
    if (selCause) begin
      rdMux = rdMux | causeView;
    end
    if (selMemv) begin
      rdMux = rdMux | memvView;
    end
    if (selStatus) begin
      rdMux = rdMux | statusView;
    end
    if (selMask) begin
      rdMux = rdMux | maskView;
    end
  end

  // A flag changing between setup and access shows on the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= rdMux;
    end
  end

endmodule

// >>> design/rcf_pkg.sv
// Shared constants for the reset-cause flag register bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package rcf_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CAUSE_N = 9;

  // Register byte offsets
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_MEMORY_VIOLATION_FLAG = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;

  // Cause register bit positions
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_RESET_INSTR = 2;
  localparam int BIT_EXT_PIN = 3;
  localparam int BIT_WDT_TIMEOUT = 4;
  localparam int BIT_WDT_WINDOW = 5;
  localparam int BIT_STK_UNDERFLOW = 6;
  localparam int BIT_STK_OVERFLOW = 7;
  // Memory-violation flag position in its own register
  localparam int BIT_MEM_VIOLATION = 1;
  // Memory-violation event index in the cause vector and irq layout
  localparam int EVT_MEM_VIOLATION = 8;

  // Values loaded by a power-on event
  localparam logic [7:0] CAUSE_POR_VAL = 8'h3C;
  localparam logic MEMORY_VIOLATION_FLAG_POR_VAL = 1'b1;

  // Value a cause drives its flag to (active level)
  localparam logic [7:0] CAUSE_ACTIVE_VAL = 8'hC0;
  localparam logic MEMORY_VIOLATION_FLAG_ACTIVE_VAL = 1'b0;

  // Writable mask of the memory-violation register
  localparam logic [7:0] MEMORY_VIOLATION_FLAG_IMPL_MASK = 8'h02;

  localparam logic [8:0] IRQ_MASK_RST = 9'h000;

endpackage

// >>> design/rcf_flag_bit.sv
// One reset-cause flag with power-on load, cause update and firmware write.
// Assumes all strobes are single-cycle pulses on clk.
`timescale 1ns/1ps
module rcf_flag_bit #(
  parameter logic POR_VAL = 1'b0,
  parameter logic ACTIVE_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic powerOnLoad,
  input wire logic causeEvt,
  input wire logic swWrite,
  input wire logic swData,
  output logic flagQ
);

  // No link to the bus reset: the flag survives every reset except power-on, which loads POR_VAL.
  always_ff @(posedge clk) begin
    if (powerOnLoad) begin
      flagQ <= POR_VAL;
    end else if (causeEvt) begin
      // Cause beats a firmware write in the same cycle
      flagQ <= ACTIVE_VAL;
    end else if (swWrite) begin
      flagQ <= swData;
    end
  end

endmodule

// >>> design/rcf_irq_status.sv
// Sticky event status with write-one-to-clear, mask and one level irq.
// Assumes event and clear inputs are on the same clock.
`timescale 1ns/1ps
module rcf_irq_status #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] eventIn,
  input wire logic clearWrite,
  input wire logic [WIDTH-1:0] clearBits,
  input wire logic maskWrite,
  input wire logic [WIDTH-1:0] maskData,
  output logic [WIDTH-1:0] statusQ,
  output logic [WIDTH-1:0] maskQ,
  output logic irq
);

  logic [WIDTH-1:0] clrVec;

  assign clrVec = clearWrite ? clearBits : '0;

  // Events raised in the last cycle of reset are still recorded; earlier ones are overwritten
  always_ff @(posedge clk) begin
    if (reset) begin
      statusQ <= eventIn;
    end else begin
      statusQ <= (statusQ & ~clrVec) | eventIn;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      maskQ <= '0;
    end else if (maskWrite) begin
      maskQ <= maskData;
    end
  end

  assign irq = |(statusQ & maskQ);

endmodule

// >>> dv/rcf_reset_cause_regs_properties.sv
// Port-level checks of the reset-cause register bank.
// Assumes zero-wait APB with read data captured in the setup cycle.
`timescale 1ns/1ps
module rcf_reset_cause_regs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcf_pkg::ADDR_W-1:0] paddr,
  input wire logic [rcf_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [rcf_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic powerOnEvt,
  input wire logic watchdogTimeoutEvt,
  input wire logic stackOverflowEvt,
  input wire logic memViolationEvt,
  input wire logic irq
);
  import rcf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic acc, rdCause, rdMemv, wrMemv;
  assign acc = psel && penable;
  assign rdCause = psel && !penable && !pwrite && paddr == OFS_CAUSE;
  assign rdMemv = psel && !penable && !pwrite && paddr == OFS_MEMORY_VIOLATION_FLAG;
  assign wrMemv = acc && pwrite && paddr == OFS_MEMORY_VIOLATION_FLAG && pstrb[0];
  //////////////////////////////////////////////////////////////////////////
  a_zero_wait: assert property (pready == acc)
    else $error("pready differs from psel and penable");
  a_unmapped_err: assert property (acc && paddr > OFS_IRQ_MASK |-> pslverr)
    else $error("no slave error on unmapped access");
  a_memory_violation_flag_unimpl: assert property (
    rdMemv |=> prdata[31:2] == 30'h0 && !prdata[0])
    else $error("unimplemented bits not zero");
  a_memory_violation_flag_readback: assert property (
    wrMemv && !memViolationEvt && !powerOnEvt ##1 rdMemv
    |=> prdata[1] == $past(pwdata[1], 2))
    else $error("memory flag write not read back");
  a_ovf_sets: assert property (
    stackOverflowEvt && !powerOnEvt ##1 rdCause |=> prdata[7])
    else $error("overflow flag not set");
  a_wdt_clears: assert property (
    watchdogTimeoutEvt && !powerOnEvt ##1 rdCause |=> !prdata[4])
    else $error("timeout flag not cleared");
  a_memory_violation_flag_clears: assert property (
    memViolationEvt && !powerOnEvt ##1 (!powerOnEvt && !wrMemv)[*2]
    ##1 rdMemv |=> !prdata[1])
    else $error("memory flag not cleared");
  a_por_load: assert property (
    powerOnEvt ##1 rdCause |=> prdata[7:0] == 8'h3C)
    else $error("power-on value wrong");
  a_irq_quiet: assert property ($past(reset) |-> !irq)
    else $error("irq high right after reset");
  c_ovf_read: cover property (stackOverflowEvt ##1 rdCause);
  c_slverr: cover property (acc && pslverr);
  c_irq: cover property (irq);
  c_memory_violation_flag_read: cover property (memViolationEvt ##3 rdMemv);
endmodule
bind rcf_reset_cause_regs rcf_reset_cause_regs_checker u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .powerOnEvt(powerOnEvt), .watchdogTimeoutEvt(watchdogTimeoutEvt),
  .stackOverflowEvt(stackOverflowEvt), .memViolationEvt(memViolationEvt),
  .irq(irq));

// >>> dv/tb_rcf_reset_cause_regs.sv
// Self-checking bench for the reset-cause register bank.
// Assumes zero-wait APB and one-cycle cause pulses on clk.
`timescale 1ns/1ps
module tb_rcf_reset_cause_regs;
  import rcf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic pready, pslverr, irq, lastErr;
  logic [8:0] evt = 9'h000;
  int err_count = 0;
  int n_checks = 0;
  rcf_reset_cause_regs DUT (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownoutEvt(evt[0]), .powerOnEvt(evt[1]), .resetInstrEvt(evt[2]),
    .extPinResetEvt(evt[3]), .watchdogTimeoutEvt(evt[4]),
    .windowViolationEvt(evt[5]), .stackUnderflowEvt(evt[6]),
    .stackOverflowEvt(evt[7]), .memViolationEvt(evt[8]), .irq(irq));
  initial forever #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Leaves psel high so a following call makes a back-to-back transfer
  task automatic apb(input logic wr, input logic [11:0] a, input int d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      close_out();
    end
    rd = prdata;
    lastErr = pslverr;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input int e);
    apb(1'b0, a, 0);
    chk(nm, rd, e);
  endtask
  task automatic idle();
    psel <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt <= 9'h000;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    pulse(1);
    rdchk("por cause", OFS_CAUSE, 32'h3C);
    rdchk("por memory_violation_flag", OFS_MEMORY_VIOLATION_FLAG, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h1FF);
    for (int i = 0; i < 9; i++) begin
      if (i == 1) continue;
      apb(1'b1, OFS_CAUSE, 32'h3F);
      apb(1'b1, OFS_MEMORY_VIOLATION_FLAG, 32'h2);
      apb(1'b1, OFS_IRQ_STATUS, 32'h1FF);
      idle();
      pulse(i);
      rdchk("cause", OFS_CAUSE, i == 8 ? 32'h3F : 32'h3F ^ (1 << i));
      rdchk("memory_violation_flag", OFS_MEMORY_VIOLATION_FLAG, i == 8 ? 32'h0 : 32'h2);
      rdchk("status", OFS_IRQ_STATUS, 1 << i);
      chk("irq", irq, 32'h1);
    end
    apb(1'b1, OFS_IRQ_STATUS, 32'h1FF);
    rdchk("w1c", OFS_IRQ_STATUS, 32'h0);
    chk("irq low", irq, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    idle();
    pulse(7);
    rdchk("masked", OFS_IRQ_STATUS, 32'h80);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, OFS_CAUSE, 32'hFFFF_FFC0);
    rdchk("fw cause", OFS_CAUSE, 32'hC0);
    apb(1'b1, OFS_MEMORY_VIOLATION_FLAG, 32'hFFFF_FFFD);
    rdchk("fw memory_violation_flag", OFS_MEMORY_VIOLATION_FLAG, 32'h0);
    rdchk("no reset", OFS_IRQ_STATUS, 32'h80);
    idle();
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdchk("kept", OFS_CAUSE, 32'hC0);
    apb(1'b0, 12'h010, 0);
    chk("unmapped", {lastErr, rd[30:0]}, 32'h8000_0000);
    idle();
    close_out();
  end
endmodule
